// file: shared/sram_pkg.sv
// Shared constants, state enumeration and carriers for the burst memory control block.
// Assumes one clock domain; the address and lane widths here are upper bounds that the modules narrow.
package sram_pkg;

	localparam int ADDR_MAX_W = 21;
	localparam int LANE_MAX = 4;
	localparam int BYTE_W = 8;
	localparam int BURST_W = 2;
	localparam int WBUF_DEPTH = 8;
	localparam logic ORDER_LINEAR = 1'b0;
	localparam logic [1:0] BURST_RST = 2'h0;
	localparam logic SYNC_RST = 1'b0;
	localparam logic ORDER_RST = 1'b1;

	typedef enum logic [1:0] {
		ST_DOWN = 2'b00,
		ST_ACTIVE = 2'b01,
		ST_SLEEP = 2'b10
	} mode_e;

	typedef struct packed {
		logic ctrl_strobe_n;
		logic proc_strobe_n;
		logic advance_n;
		logic global_write_n;
		logic byte_gate_n;
		logic [LANE_MAX-1:0] lane_n;
		logic ce_primary_n;
		logic ce_high;
		logic ce_secondary_n;
	} ctl_s;

	localparam ctl_s CTL_IDLE = '{
		ctrl_strobe_n: 1'b1,
		proc_strobe_n: 1'b1,
		advance_n: 1'b1,
		global_write_n: 1'b1,
		byte_gate_n: 1'b1,
		lane_n: 4'hf,
		ce_primary_n: 1'b1,
		ce_high: 1'b0,
		ce_secondary_n: 1'b1
	};

	typedef struct packed {
		logic [ADDR_MAX_W-1:0] addr;
		logic [LANE_MAX-1:0] mask;
		logic [LANE_MAX*BYTE_W-1:0] data;
		logic [LANE_MAX-1:0] parity;
	} wr_s;

endpackage

// file: design/wr_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module wr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk, // Clock.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic in_valid, // Entry offered.
	output logic in_ready, // Room for an entry.
	input wire logic [WIDTH-1:0] in_data, // Entry offered.
	output logic out_valid, // Entry available.
	input wire logic out_ready, // Sink takes the entry.
	output logic [WIDTH-1:0] out_data // Oldest entry.
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW:0] wr_ptr_q;
	logic [PW:0] rd_ptr_q;
	logic push;
	logic pop;

	assign out_valid = wr_ptr_q != rd_ptr_q;
	assign in_ready = !((wr_ptr_q[PW] != rd_ptr_q[PW]) && (wr_ptr_q[PW-1:0] == rd_ptr_q[PW-1:0]));
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_ptr_q[PW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q[PW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_q <= '0;
		end else if (push) begin
			wr_ptr_q <= wr_ptr_q + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_ptr_q <= '0;
		end else if (pop) begin
			rd_ptr_q <= rd_ptr_q + 1'b1;
		end
	end

endmodule // wr_fifo

// file: design/sram_core_ctrl.sv
// Control logic of a pipelined synchronous burst memory: pin registers, access decode,
// burst counter, byte-lane write buffer and read data output stage.
// Assumes the master runs on clk and the storage array sits outside on the arr_* ports.
`timescale 1ns/1ps
module sram_core_ctrl
	import sram_pkg::*;
#(
	parameter int ADDR_W = 19,
	parameter int LANES = 4,
	parameter bit PARITY = 1'b1
) (
	input wire logic clk, // Clock, rising edge.
	input wire logic resetn, // Asynchronous reset, active low.
	input wire logic controller_addr_strobe_n, // Controller address strobe.
	input wire logic processor_addr_strobe_n, // Processor address strobe.
	input wire logic burst_advance_n, // Burst advance.
	input wire logic global_write_n, // Global write.
	input wire logic byte_write_gate_n, // Byte write gate.
	input wire logic byte_write_lane_a_n, // Lane a write select.
	input wire logic byte_write_lane_b_n, // Lane b write select.
	input wire logic byte_write_lane_c_n, // Lane c write select.
	input wire logic byte_write_lane_d_n, // Lane d write select.
	input wire logic chip_enable_primary_n, // Primary chip enable.
	input wire logic chip_enable_high, // Active-high chip enable.
	input wire logic chip_enable_secondary_n, // Secondary chip enable.
	input wire logic linear_order_select_n, // Low selects linear burst order.
	input wire logic output_drive_enable_n, // Asynchronous output enable.
	input wire logic sleep_request, // Asynchronous sleep request.
	input wire logic [ADDR_W-1:0] address_in, // Address, lsb0 and lsb1 in bits 0 and 1.
	input wire logic [LANES*BYTE_W-1:0] data_lane_in, // Data pins in, lane a lowest.
	output logic [LANES*BYTE_W-1:0] data_lane_out, // Data pins out.
	output logic [LANES*BYTE_W-1:0] data_lane_oe, // Data pin drive enables.
	input wire logic [LANES-1:0] parity_lane_in, // Parity pins in.
	output logic [LANES-1:0] parity_lane_out, // Parity pins out.
	output logic [LANES-1:0] parity_lane_oe, // Parity pin drive enables.
	output logic standby, // High while not in an access.
	output logic write_buffer_ready, // Write buffer has room.
	output logic arr_rd, // Array read strobe.
	output logic [ADDR_W-1:0] arr_raddr, // Array read address.
	input wire logic [LANES*BYTE_W-1:0] arr_rdata, // Array read data, same cycle.
	input wire logic [LANES-1:0] arr_rparity, // Array read parity, same cycle.
	output logic arr_wvalid, // Array write request.
	input wire logic arr_wready, // Array accepts the write.
	output logic [ADDR_W-1:0] arr_waddr, // Array write address.
	output logic [LANES-1:0] arr_wmask, // Array write lane mask.
	output logic [LANES*BYTE_W-1:0] arr_wdata, // Array write data.
	output logic [LANES-1:0] arr_wparity // Array write parity.
);

	localparam int DW = LANES * BYTE_W;
	localparam int HI_W = ADDR_W - BURST_W;

	function automatic logic [BURST_W-1:0] burst_lo(input logic [BURST_W-1:0] start,
		input logic [BURST_W-1:0] cnt, input logic linear);
		if (linear) begin
			burst_lo = start + cnt;
		end else begin
			burst_lo = start ^ cnt;
		end
	endfunction

	function automatic logic [LANES-1:0] write_mask(input ctl_s c);
		if (!c.global_write_n) begin
			write_mask = '1;
		end else if (!c.byte_gate_n) begin
			write_mask = ~c.lane_n[LANES-1:0];
		end else begin
			write_mask = '0;
		end
	endfunction

	ctl_s ctl_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DW-1:0] din_q;
	logic [LANES-1:0] pin_q;
	logic sleep_meta_q;
	logic sleep_q;
	logic order_meta_q;
	logic order_q;
	mode_e mode_q;
	mode_e mode_d;
	logic [HI_W-1:0] base_q;
	logic [HI_W-1:0] base_d;
	logic [BURST_W-1:0] start_q;
	logic [BURST_W-1:0] start_d;
	logic [BURST_W-1:0] cnt_q;
	logic [BURST_W-1:0] cnt_d;
	logic [ADDR_W-1:0] cur_addr;
	logic [LANES-1:0] mask;
	logic selected;
	logic load;
	logic rd_d;
	logic wr_d;
	logic rd_q;
	logic [ADDR_W-1:0] raddr_q;
	logic drive_q;
	logic [DW-1:0] out_q;
	logic [LANES-1:0] pout_q;
	logic drive;
	wr_s push_data;
	wr_s pop_data;
	logic fifo_ready;

	// Every synchronous pin lands in a register on the rising edge.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctl_q <= CTL_IDLE;
		end else begin
			ctl_q.ctrl_strobe_n <= controller_addr_strobe_n;
			ctl_q.proc_strobe_n <= processor_addr_strobe_n;
			ctl_q.advance_n <= burst_advance_n;
			ctl_q.global_write_n <= global_write_n;
			ctl_q.byte_gate_n <= byte_write_gate_n;
			ctl_q.lane_n <= {byte_write_lane_d_n, byte_write_lane_c_n,
				byte_write_lane_b_n, byte_write_lane_a_n};
			ctl_q.ce_primary_n <= chip_enable_primary_n;
			ctl_q.ce_high <= chip_enable_high;
			ctl_q.ce_secondary_n <= chip_enable_secondary_n;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addr_q <= '0;
			din_q <= '0;
			pin_q <= '0;
		end else begin
			addr_q <= address_in;
			din_q <= data_lane_in;
			pin_q <= PARITY ? parity_lane_in : '0;
		end
	end

	// Sleep and order select are not synchronous to clk, so each passes two flops.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sleep_meta_q <= SYNC_RST;
			sleep_q <= SYNC_RST;
		end else begin
			sleep_meta_q <= sleep_request;
			sleep_q <= sleep_meta_q;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			order_meta_q <= ORDER_RST;
			order_q <= ORDER_RST;
		end else begin
			order_meta_q <= linear_order_select_n;
			order_q <= order_meta_q;
		end
	end

	// Enables only matter in a cycle that loads an address.
	assign selected = !ctl_q.ce_primary_n && ctl_q.ce_high && !ctl_q.ce_secondary_n;
	assign mask = write_mask(ctl_q);

	always_comb begin
		mode_d = mode_q;
		load = 1'b0;
		rd_d = 1'b0;
		wr_d = 1'b0;
		cnt_d = cnt_q;
		if (sleep_q) begin
			mode_d = ST_SLEEP;
		end else if (!ctl_q.proc_strobe_n && !ctl_q.ce_primary_n) begin
			load = 1'b1;
			if (selected) begin
				mode_d = ST_ACTIVE;
				rd_d = 1'b1;
			end else begin
				mode_d = ST_DOWN;
			end
		end else if (!ctl_q.ctrl_strobe_n) begin
			load = 1'b1;
			if (selected) begin
				mode_d = ST_ACTIVE;
				wr_d = |mask;
				rd_d = ~|mask;
			end else begin
				mode_d = ST_DOWN;
			end
		end else begin
			unique case (mode_q)
				ST_ACTIVE: begin
					if (!ctl_q.advance_n) begin
						cnt_d = cnt_q + 1'b1;
					end
					wr_d = |mask;
					rd_d = ~|mask;
				end
				ST_SLEEP: begin
					mode_d = ST_DOWN;
				end
				ST_DOWN: begin
					mode_d = ST_DOWN;
				end
				default: begin
					mode_d = ST_DOWN;
				end
			endcase
		end
		if (load) begin
			cnt_d = BURST_RST;
		end
	end

	assign base_d = load ? addr_q[ADDR_W-1:BURST_W] : base_q;
	assign start_d = load ? addr_q[BURST_W-1:0] : start_q;
	assign cur_addr = {base_d, burst_lo(start_d, cnt_d, order_q == ORDER_LINEAR)};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= ST_DOWN;
		end else begin
			mode_q <= mode_d;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			base_q <= '0;
			start_q <= BURST_RST;
			cnt_q <= BURST_RST;
		end else begin
			base_q <= base_d;
			start_q <= start_d;
			cnt_q <= cnt_d;
		end
	end

	// Read pipeline: address to the array, then data into the output register.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_q <= 1'b0;
			raddr_q <= '0;
		end else begin
			rd_q <= rd_d;
			raddr_q <= cur_addr;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			drive_q <= 1'b0;
			out_q <= '0;
			pout_q <= '0;
		end else begin
			drive_q <= rd_q && !sleep_q;
			if (rd_q) begin
				out_q <= arr_rdata;
				pout_q <= PARITY ? arr_rparity : '0;
			end
		end
	end

	assign arr_rd = rd_q;
	assign arr_raddr = raddr_q;

	// Output enable acts without the clock on the driver gate.
	assign drive = drive_q && !output_drive_enable_n && !sleep_q;
	assign data_lane_out = out_q;
	assign data_lane_oe = {DW{drive}};
	assign parity_lane_out = pout_q;
	assign parity_lane_oe = {LANES{drive && PARITY}};

	// Writes wait here for the array; a write offered while full is lost.
	always_comb begin
		push_data = '0;
		push_data.addr = ADDR_MAX_W'(cur_addr);
		push_data.mask = LANE_MAX'(mask);
		push_data.data = (LANE_MAX * BYTE_W)'(din_q);
		push_data.parity = LANE_MAX'(pin_q);
	end

	wr_fifo #(
		.WIDTH($bits(wr_s)),
		.DEPTH(WBUF_DEPTH)
	) u_wbuf (
		.clk(clk),
		.resetn(resetn),
		.in_valid(wr_d),
		.in_ready(fifo_ready),
		.in_data(push_data),
		.out_valid(arr_wvalid),
		.out_ready(arr_wready),
		.out_data(pop_data)
	);

	assign write_buffer_ready = fifo_ready;
	assign arr_waddr = pop_data.addr[ADDR_W-1:0];
	assign arr_wmask = pop_data.mask[LANES-1:0];
	assign arr_wdata = pop_data.data[DW-1:0];
	assign arr_wparity = pop_data.parity[LANES-1:0];
	assign standby = mode_q != ST_ACTIVE;

endmodule // sram_core_ctrl

// file: verification/sram_chk.sv
// Pin-level timing checks for the burst memory control block.
// Assumes it is bound into sram_core_ctrl and sees only its ports.
`timescale 1ns/1ps
module sram_chk
	import sram_pkg::*;
#(
	parameter int ADDR_W = 19,
	parameter int LANES = 4
) (
	input wire logic clk, // Clock.
	input wire logic resetn, // Reset.
	input wire logic controller_addr_strobe_n, // Strobe.
	input wire logic processor_addr_strobe_n, // Strobe.
	input wire logic burst_advance_n, // Advance.
	input wire logic global_write_n, // Write all.
	input wire logic byte_write_gate_n, // Lane gate.
	input wire logic chip_enable_primary_n, // Enable.
	input wire logic chip_enable_high, // Enable.
	input wire logic chip_enable_secondary_n, // Enable.
	input wire logic output_drive_enable_n, // Drive gate.
	input wire logic sleep_request, // Sleep.
	input wire logic [ADDR_W-1:0] address_in, // Address.
	input wire logic [LANES*BYTE_W-1:0] data_lane_oe, // Drives.
	input wire logic standby, // Idle.
	input wire logic write_buffer_ready, // Room.
	input wire logic arr_rd, // Read.
	input wire logic [ADDR_W-1:0] arr_raddr, // Read address.
	input wire logic arr_wvalid // Write.
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	wire sel = !chip_enable_primary_n && chip_enable_high && !chip_enable_secondary_n;
	wire wait_pins = controller_addr_strobe_n && processor_addr_strobe_n && global_write_n
		&& byte_write_gate_n && burst_advance_n;

	AST_READ_START:
	assert property ((!sleep_request)[*5] ##0 (sel && (!processor_addr_strobe_n
		|| (!controller_addr_strobe_n && global_write_n && byte_write_gate_n)))
		|-> ##2 arr_rd && arr_raddr == $past(address_in, 2)) else $error("no read");
	AST_CTRL_DOWN:
	assert property (!controller_addr_strobe_n && chip_enable_primary_n
		|-> ##2 standby && !arr_rd) else $error("no power down");
	AST_PROC_DOWN:
	assert property (!processor_addr_strobe_n && !chip_enable_primary_n
		&& !(chip_enable_high && !chip_enable_secondary_n)
		|-> ##2 standby && !arr_rd) else $error("no power down");
	AST_OE_GATE:
	assert property (output_drive_enable_n |-> data_lane_oe == '0) else $error("drives on");
	AST_ONE_DESELECT:
	assert property (!arr_rd |=> data_lane_oe == '0) else $error("late release");
	AST_WRITE_GLOBAL:
	assert property ((!sleep_request)[*5] ##0 (sel && !controller_addr_strobe_n
		&& processor_addr_strobe_n && !global_write_n) ##1 write_buffer_ready
		|=> arr_wvalid && !arr_rd) else $error("no write");
	AST_HOLD:
	assert property ((!sleep_request)[*5] ##0 wait_pins ##1 arr_rd
		|=> arr_rd && $stable(arr_raddr)) else $error("address moved");
	AST_SLEEP:
	assert property (sleep_request[*6] |-> standby && !arr_rd) else $error("awake");
endmodule // sram_chk

bind sram_core_ctrl sram_chk #(.ADDR_W(ADDR_W), .LANES(LANES)) chk_i (.*);

// file: verification/arr_model.sv
// Storage array model behind the block's array ports.
// Assumes one clock; hold stalls write acceptance.
`timescale 1ns/1ps
module arr_model (
	input wire logic clk, // Clock.
	input wire logic hold, // Stall.
	input wire logic arr_rd, // Read.
	input wire logic [18:0] arr_raddr, // Address.
	output logic [31:0] arr_rdata, // Data.
	output logic [3:0] arr_rparity, // Parity.
	input wire logic arr_wvalid, // Write.
	output logic arr_wready, // Taken.
	input wire logic [18:0] arr_waddr, // Address.
	input wire logic [3:0] arr_wmask, // Lanes.
	input wire logic [31:0] arr_wdata, // Data.
	input wire logic [3:0] arr_wparity // Parity.
);
	logic [35:0] mem [16];
	assign arr_wready = !hold;
	// Outside a read the lines show the inverse, so a mistimed sample cannot match.
	assign {arr_rparity, arr_rdata} = arr_rd ? mem[arr_raddr[3:0]] : ~mem[arr_raddr[3:0]];
	always @(posedge clk)
		if (arr_wvalid && arr_wready)
			for (int l = 0; l < 4; l++)
				if (arr_wmask[l]) begin
					mem[arr_waddr[3:0]][l*8+:8] <= arr_wdata[l*8+:8];
					mem[arr_waddr[3:0]][32+l] <= arr_wparity[l];
				end
endmodule // arr_model

// file: verification/tb_top.sv
// Self-checking bench for the burst memory control block.
// Assumes the array model behind it and the bound checker.
`timescale 1ns/1ps
module tb_top;
	import sram_pkg::*;
	localparam ctl_s SEL = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hf, 1'b0, 1'b1, 1'b0};
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic hold = 1'b1;
	logic stall_all = 1'b0;
	logic linear_order_select_n, output_drive_enable_n, sleep_request;
	logic [18:0] address_in, arr_raddr, arr_waddr;
	logic [31:0] data_lane_in, data_lane_out, data_lane_oe, arr_rdata, arr_wdata;
	logic [3:0] parity_lane_in, parity_lane_out, parity_lane_oe, arr_rparity, arr_wmask;
	logic [3:0] arr_wparity;
	logic standby, write_buffer_ready, arr_rd, arr_wvalid, arr_wready;
	wire controller_addr_strobe_n, processor_addr_strobe_n, burst_advance_n, global_write_n;
	wire byte_write_gate_n, byte_write_lane_a_n, byte_write_lane_b_n, byte_write_lane_c_n;
	wire byte_write_lane_d_n, chip_enable_primary_n, chip_enable_high, chip_enable_secondary_n;
	ctl_s c;
	logic [35:0] sh [16];
	int seed = 32'h160712ea;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	assign {controller_addr_strobe_n, processor_addr_strobe_n, burst_advance_n, global_write_n,
		byte_write_gate_n, byte_write_lane_d_n, byte_write_lane_c_n, byte_write_lane_b_n,
		byte_write_lane_a_n, chip_enable_primary_n, chip_enable_high, chip_enable_secondary_n} = c;
	sram_core_ctrl dut (.*);
	arr_model array_i (.*);
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		hold <= stall_all | 1'($random(seed));
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			test_done();
		end
	end
	task automatic test_done();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(logic [35:0] seen, logic [35:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t %h %h", $time, seen, exp);
		end
	endtask
	function automatic logic [1:0] nb(logic [1:0] s, int i);
		return (linear_order_select_n === 1'b0) ? s + 2'(i) : s ^ 2'(i);
	endfunction
	function automatic logic [35:0] rnd();
		return {4'($random(seed)), 32'($random(seed))};
	endfunction
	task automatic pin(ctl_s v, logic [18:0] a, logic [35:0] d);
		@(posedge clk);
		c <= v;
		address_in <= a;
		{parity_lane_in, data_lane_in} <= d;
	endtask
	task automatic settle();
		@(posedge clk);
		#1;
	endtask
	task automatic wburst(logic [3:0] a);
		ctl_s v;
		logic [35:0] d;
		v = SEL;
		v.ctrl_strobe_n = 1'b0;
		v.global_write_n = 1'b0;
		for (int i = 0; i < 4; i++) begin
			d = rnd();
			sh[{a[3:2], nb(a[1:0], i)}] = d;
			pin(v, i ? 19'($random(seed)) : 19'(a), d);
			v.ctrl_strobe_n = 1'b1;
			v.ce_primary_n = 1'b1;
			v.advance_n = 1'b0;
		end
	endtask
	task automatic bwrite(logic [3:0] a);
		ctl_s v;
		logic [35:0] d;
		v = SEL;
		// A processor start leaves advance high, so the next cycle writes the loaded address.
		if (1'($random(seed))) begin
			v.proc_strobe_n = 1'b0;
			pin(v, 19'(a), '0);
			v = SEL;
		end else begin
			v.ctrl_strobe_n = 1'b0;
		end
		v.byte_gate_n = 1'($random(seed));
		v.lane_n = 4'($random(seed));
		d = rnd();
		for (int l = 0; l < 4; l++)
			if (!v.byte_gate_n && !v.lane_n[l]) begin
				sh[a][l*8+:8] = d[l*8+:8];
				sh[a][32+l] = d[32+l];
			end
		pin(v, 19'(a), d);
	endtask
	task automatic drain();
		pin(CTL_IDLE, '0, '0);
		repeat (3) settle();
		while (arr_wvalid !== 1'b0) settle();
	endtask
	task automatic rburst(logic [3:0] a);
		ctl_s v;
		int n;
		v = SEL;
		v.proc_strobe_n = 1'b0;
		for (int j = 0; j < 9; j++) begin
			pin(v, 19'(a), rnd());
			output_drive_enable_n <= (j == 6);
			#1;
			n = (j < 5) ? 0 : j - 4;
			if (j >= 3 && j < 8)
				chk({parity_lane_out, data_lane_out}, sh[{a[3:2], nb(a[1:0], n)}]);
			if (j >= 3)
				chk({parity_lane_oe, data_lane_oe}, {36{j != 6 && j != 8}});
			v = SEL;
			v.ctrl_strobe_n = (j < 4);
			v.ce_primary_n = 1'b1;
			v.advance_n = (j == 0);
		end
	endtask
	task automatic pokes();
		ctl_s v;
		for (int k = 0; k < 2; k++) begin
			v = SEL;
			v.proc_strobe_n = 1'b0;
			pin(v, 19'h5, '0);
			v.ce_primary_n = 1'b1;
			pin(v, 19'h9, '0);
			pin(CTL_IDLE, '0, '0);
			settle();
			chk({arr_rd, arr_raddr}, {1'b1, 19'h5});
			v = SEL;
			v.ctrl_strobe_n = k[0];
			v.proc_strobe_n = !k[0];
			v.ce_high = k[0];
			v.ce_secondary_n = k[0];
			pin(v, '0, '0);
			pin(CTL_IDLE, '0, '0);
			settle();
			chk(standby, 1'b1);
		end
		v = SEL;
		v.proc_strobe_n = 1'b0;
		pin(v, 19'h3, '0);
		sleep_request <= 1'b1;
		repeat (6) pin(v, 19'h3, '0);
		settle();
		chk({standby, arr_rd}, 2'b10);
		pin(CTL_IDLE, '0, '0);
		sleep_request <= 1'b0;
	endtask
	initial begin
		logic [3:0] a;
		ctl_s v;
		c = CTL_IDLE;
		address_in = '0;
		data_lane_in = '0;
		parity_lane_in = '0;
		output_drive_enable_n = 1'b0;
		sleep_request = 1'b0;
		linear_order_select_n = 1'b0;
		for (int m = 0; m < 2; m++) begin
			@(posedge clk);
			resetn <= 1'b0;
			linear_order_select_n <= m[0];
			repeat (5) @(posedge clk);
			resetn <= 1'b1;
			#1 chk({standby, data_lane_oe}, {1'b1, 32'h0});
			for (int i = 0; i < 8; i++) begin
				a = 4'($random(seed));
				wburst(a);
				bwrite({a[3:2], 2'($random(seed))});
				drain();
				rburst(a);
			end
			pokes();
			drain();
			stall_all <= 1'b1;
			v = SEL;
			v.ctrl_strobe_n = 1'b0;
			v.global_write_n = 1'b0;
			for (int i = 0; i < 8; i++) begin
				sh[i] = rnd();
				pin(v, 19'(i), sh[i]);
			end
			pin(CTL_IDLE, '0, '0);
			settle();
			chk(write_buffer_ready, 1'b0);
			stall_all <= 1'b0;
			drain();
			rburst(4'h2);
		end
		test_done();
	end
endmodule // tb_top
